// ===== rtl/rsl_pkg.sv
// constants and carrier types for the reset strap latch
// assumes one 20 MHz clock and a synchronous active-high core reset
//
// Function
// RULE1: capture strap levels when chip reset releases
// RULE2: chip reset clears every internal module; straps, pullups, clock test and scan steering are not cleared here
// RULE3: expander pullup strap drives sixteen pullup enables
// RULE4: remap replaces lpc address bits twenty..seventeen
// RULE5: remap disable strap high keeps default mapping
// RULE6: map register bit five shows inverted disable
// RULE7: boot enable copied to flash and id bits
// RULE8: boot enable strap gates host bios access
// RULE9: clock test strap selects clock test mode
// RULE10: pll test strap reroutes scan outputs
// RULE11: drive host reset request low for reset
// RULE12: sci output low while event outstanding
// RULE13: latched values hold until next release
// RULE14: shared pins return to normal after release
package rsl_pkg;
    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int RSL_ADDR_W = 24;        // lpc address width
    localparam int RSL_REMAP_HI = 20;      // top remapped address bit
    localparam int RSL_REMAP_LO = 17;      // bottom remapped address bit
    localparam int RSL_REMAP_W = 4;        // remap field width
    localparam int RSL_XCS_N = 16;         // expander chip selects
    localparam int RSL_SCAN_N = 16;        // scan lines 0..15
    localparam int RSL_CSM_BIT = 5;        // map register remap bit
    localparam int RSL_FWH_BIT = 4;        // hub id register boot bit
    localparam int RSL_FEN_W = 4;          // flash enable boot bits 3..0
    localparam int RSL_REG_W = 8;          // register byte width
    localparam logic [7:0] RSL_REG_ZERO = 8'h00;  // reset register value
    localparam logic [3:0] RSL_REMAP_RST = 4'h0;  // remap register reset
    localparam int RSL_SYNC_N = 2;         // reset pin sampling depth

    // latched strap set
    typedef struct packed {
        logic expander_pullup;
        logic remap_disable;
        logic boot_memory_enable;
        logic clock_test;
        logic pll_test;
    } rsl_strap_t;

    localparam rsl_strap_t RSL_STRAP_RST = '0;   // values loaded by system reset
endpackage

// ===== rtl/rsl_reset_strap_latch.sv
// strap latch: catches straps on chip reset release, fans them out
// assumes strap pins are stable at release; i_rst is the system reset
`timescale 1ns/100ps
`default_nettype none
module rsl_reset_strap_latch
    import rsl_pkg::*;
#(
    parameter int ADDR_W = RSL_ADDR_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_chip_reset_in_n,          // global reset pin
    input wire rsl_strap_t i_strap_pins,         // shared strap pin levels
    input wire logic [ADDR_W-1:0] i_lpc_addr,    // lpc memory address
    input wire logic [RSL_REMAP_W-1:0] i_remap_address_reg,
    input wire logic i_remap_wr,                 // remap register write
    input wire logic i_host_bios_req,            // host bios cycle request
    input wire logic [RSL_SCAN_N-1:0] i_scan_normal,
    input wire logic i_scan_16_normal,
    input wire logic [RSL_SCAN_N-1:0] i_pll_data,
    input wire logic i_por,                      // internal power-on reset
    input wire logic i_host_reset_req,           // ask for system reset
    input wire logic i_sci_pending,              // sci event outstanding
    output logic o_in_reset,                     // chip held in reset
    output rsl_strap_t o_strap,                  // latched values
    output logic [RSL_XCS_N-1:0] o_expander_pullup_en,
    output logic [ADDR_W-1:0] o_xbus_addr,
    output logic [RSL_REG_W-1:0] o_lpc_chip_select_map_reg,
    output logic [RSL_REG_W-1:0] o_lpc_flash_enable_reg,
    output logic [RSL_REG_W-1:0] o_firmware_hub_id_reg,
    output logic o_host_bios_grant,
    output logic o_clock_test_mode,
    output logic [RSL_SCAN_N-1:0] o_scan_output_lines,
    output logic o_scan_output_16,
    output logic o_host_reset_request_n,
    output logic o_sci_event_out_n,
    output logic o_pins_released                 // shared pins in normal role
);
    // ------------------------------------------------------------
    // reset pin sampling and release detect
    // ------------------------------------------------------------
    logic rst_pin_s;          // synchronised reset pin
    logic rst_pin_d;          // previous sample for the edge
    logic chip_rst;           // internal chip reset, high while held
    logic release_evt;        // one cycle at rising edge of pin
    logic [RSL_REMAP_W-1:0] remap_q;   // remap register copy

    rsl_sync #(
        .STAGES(RSL_SYNC_N)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_d(i_chip_reset_in_n),
        .o_q(rst_pin_s)
    );

    // edge memory; system reset parks it low so a high pin releases
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rst_pin_d <= 1'b0;
        end else begin
            rst_pin_d <= rst_pin_s;
        end
    end

    assign release_evt = rst_pin_s & ~rst_pin_d;   // see RULE1
    assign chip_rst = i_rst | ~rst_pin_s;          // see RULE2

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // latch only at release; pins are then free, value held
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_strap <= RSL_STRAP_RST;
        end else if (release_evt) begin
            o_strap <= i_strap_pins;   // see RULE1
        end
        // otherwise hold whatever the pins do afterwards, see RULE13 RULE14
    end

    // pins show strap role until release, then normal role
    always_ff @(posedge i_ref_clk) begin
        if (chip_rst) begin
            o_pins_released <= 1'b0;
        end else begin
            o_pins_released <= 1'b1;   // see RULE14
        end
        o_in_reset <= chip_rst;        // see RULE2
    end

    // ------------------------------------------------------------
    // remap register and address path
    // ------------------------------------------------------------
    // register cleared with the chip, loaded by firmware write
    always_ff @(posedge i_ref_clk) begin
        if (chip_rst) begin
            remap_q <= RSL_REMAP_RST;   // see RULE2
        end else if (i_remap_wr) begin
            remap_q <= i_remap_address_reg;
        end
    end

    // replace bits 20..17 only when remap is enabled (strap low)
    always_ff @(posedge i_ref_clk) begin
        if (chip_rst) begin
            o_xbus_addr <= '0;
        end else if (!o_strap.remap_disable) begin
            o_xbus_addr <= i_lpc_addr;
            o_xbus_addr[RSL_REMAP_HI:RSL_REMAP_LO] <= remap_q;   // see RULE4 RULE5
        end else begin
            o_xbus_addr <= i_lpc_addr;   // default mapping, see RULE5
        end
    end

    // ------------------------------------------------------------
    // register mirrors
    // ------------------------------------------------------------
    // other bits of these registers live elsewhere and read zero here
    always_ff @(posedge i_ref_clk) begin
        if (chip_rst) begin
            o_lpc_chip_select_map_reg <= RSL_REG_ZERO;
            o_lpc_flash_enable_reg <= RSL_REG_ZERO;
            o_firmware_hub_id_reg <= RSL_REG_ZERO;
        end else begin
            o_lpc_chip_select_map_reg <= RSL_REG_ZERO;
            o_lpc_chip_select_map_reg[RSL_CSM_BIT] <= ~o_strap.remap_disable;  // see RULE6
            o_lpc_flash_enable_reg <= RSL_REG_ZERO;
            o_lpc_flash_enable_reg[RSL_FEN_W-1:0] <=
                {RSL_FEN_W{o_strap.boot_memory_enable}};  // see RULE7
            o_firmware_hub_id_reg <= RSL_REG_ZERO;
            o_firmware_hub_id_reg[RSL_FWH_BIT] <= o_strap.boot_memory_enable;  // see RULE7
        end
    end

    // ------------------------------------------------------------
    // mode controls from the straps
    // ------------------------------------------------------------
    // pullups stay on during reset too, value from the last latch
    always_ff @(posedge i_ref_clk) begin
        o_expander_pullup_en <= {RSL_XCS_N{o_strap.expander_pullup}};   // see RULE3
        o_clock_test_mode <= o_strap.clock_test;                         // see RULE9
    end

    // host bios access gated by the boot strap
    always_ff @(posedge i_ref_clk) begin
        if (chip_rst) begin
            o_host_bios_grant <= 1'b0;
        end else begin
            o_host_bios_grant <= i_host_bios_req & o_strap.boot_memory_enable;  // see RULE8
        end
    end

    // scan output steering; test data replaces normal scan drive
    always_ff @(posedge i_ref_clk) begin
        if (o_strap.pll_test) begin
            o_scan_output_lines <= i_pll_data;   // see RULE10
            o_scan_output_16 <= i_por;           // see RULE10
        end else begin
            o_scan_output_lines <= i_scan_normal;
            o_scan_output_16 <= i_scan_16_normal;
        end
    end

    // ------------------------------------------------------------
    // host signalling
    // ------------------------------------------------------------
    // both outputs idle high while the chip is held in reset
    always_ff @(posedge i_ref_clk) begin
        if (chip_rst) begin
            o_host_reset_request_n <= 1'b1;
            o_sci_event_out_n <= 1'b1;
        end else begin
            o_host_reset_request_n <= ~i_host_reset_req;   // see RULE11
            o_sci_event_out_n <= ~i_sci_pending;           // see RULE12
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_capture;
        @(posedge i_ref_clk) disable iff (i_rst)
        release_evt |=> (o_strap == $past(i_strap_pins));
    endproperty
    a_capture: assert property (p_capture) else $error("strap not captured"); // see RULE1

    property p_hold;
        @(posedge i_ref_clk) disable iff (i_rst)
        !release_evt |=> $stable(o_strap);
    endproperty
    a_hold: assert property (p_hold) else $error("strap changed"); // see RULE13

    property p_reset;
        @(posedge i_ref_clk) disable iff (i_rst)
        !rst_pin_s |=> (o_in_reset && !o_pins_released && o_sci_event_out_n);
    endproperty
    a_reset: assert property (p_reset) else $error("reset not applied"); // see RULE2

    property p_pullup;
        @(posedge i_ref_clk) disable iff (i_rst)
        ##1 o_expander_pullup_en == {RSL_XCS_N{$past(o_strap.expander_pullup)}};
    endproperty
    a_pullup: assert property (p_pullup) else $error("pullup mismatch"); // see RULE3

    property p_remap;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!chip_rst && !o_strap.remap_disable)
            |=> o_xbus_addr[RSL_REMAP_HI:RSL_REMAP_LO] == $past(remap_q);
    endproperty
    a_remap: assert property (p_remap) else $error("remap bits wrong"); // see RULE4

    property p_noremap;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!chip_rst && o_strap.remap_disable) |=> o_xbus_addr == $past(i_lpc_addr);
    endproperty
    a_noremap: assert property (p_noremap) else $error("default map wrong"); // see RULE5

    property p_csm;
        @(posedge i_ref_clk) disable iff (i_rst)
        !chip_rst |=> o_lpc_chip_select_map_reg[RSL_CSM_BIT] == !$past(o_strap.remap_disable);
    endproperty
    a_csm: assert property (p_csm) else $error("map bit wrong"); // see RULE6

    property p_fen;
        @(posedge i_ref_clk) disable iff (i_rst)
        !chip_rst |=> (o_lpc_flash_enable_reg[RSL_FEN_W-1:0] ==
            {RSL_FEN_W{$past(o_strap.boot_memory_enable)}})
            && (o_firmware_hub_id_reg[RSL_FWH_BIT] == $past(o_strap.boot_memory_enable));
    endproperty
    a_fen: assert property (p_fen) else $error("boot mirror mismatch"); // see RULE7

    property p_bios;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_host_bios_grant |-> $past(o_strap.boot_memory_enable && i_host_bios_req);
    endproperty
    a_bios: assert property (p_bios) else $error("bios grant illegal"); // see RULE8

    property p_pll;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_strap.pll_test |=> (o_scan_output_16 == $past(i_por));
    endproperty
    a_pll: assert property (p_pll) else $error("scan 16 wrong"); // see RULE10

    property p_sci;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!chip_rst && i_sci_pending) |=> !o_sci_event_out_n;
    endproperty
    a_sci: assert property (p_sci) else $error("sci not asserted"); // see RULE12

    property p_host_req;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!chip_rst && i_host_reset_req) |=> !o_host_reset_request_n;
    endproperty
    a_host_req: assert property (p_host_req) else $error("reset request missing"); // see RULE11

    // ------------------------------------------------------------
    // release walk and further guards
    // ------------------------------------------------------------
    // synced pin seen low, then high: the release edge
    sequence s_pin_rise;
        !rst_pin_s ##1 rst_pin_s;
    endsequence

    // straps land, chip leaves reset, then mirrors follow a cycle on
    sequence s_release_done;
        (o_strap == $past(i_strap_pins) && !o_in_reset && o_pins_released)
            ##1 (o_in_reset ||
                o_firmware_hub_id_reg[RSL_FWH_BIT] == o_strap.boot_memory_enable);
    endsequence

    property p_walk;
        @(posedge i_ref_clk) disable iff (i_rst)
        s_pin_rise |=> s_release_done;
    endproperty
    a_walk: assert property (p_walk) else $error("release walk broken"); // see RULE1

    property p_clock_test;
        @(posedge i_ref_clk) disable iff (i_rst)
        1'b1 |=> o_clock_test_mode == $past(o_strap.clock_test);
    endproperty
    a_clock_test: assert property (p_clock_test) else $error("clock test mode wrong"); // see RULE9

    property p_scan_lines;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_strap.pll_test |=> o_scan_output_lines == $past(i_pll_data);
    endproperty
    a_scan_lines: assert property (p_scan_lines) else $error("pll data missing"); // see RULE10

    // normal scan drive must pass untouched when the test strap is low
    property p_scan_normal;
        @(posedge i_ref_clk) disable iff (i_rst)
        !o_strap.pll_test |=> (o_scan_output_lines == $past(i_scan_normal)
            && o_scan_output_16 == $past(i_scan_16_normal));
    endproperty
    a_scan_normal: assert property (p_scan_normal) else $error("scan drive wrong"); // see RULE10

    property p_released;
        @(posedge i_ref_clk) disable iff (i_rst)
        !chip_rst |=> o_pins_released;
    endproperty
    a_released: assert property (p_released) else $error("pins not released"); // see RULE14

    // chip reset must also clear the remap copy, not only the outputs
    property p_clear;
        @(posedge i_ref_clk) disable iff (i_rst)
        chip_rst |=> (remap_q == RSL_REMAP_RST && o_xbus_addr == '0
            && !o_host_bios_grant && o_host_reset_request_n);
    endproperty
    a_clear: assert property (p_clear) else $error("chip reset incomplete"); // see RULE2

    property p_grant;
        @(posedge i_ref_clk) disable iff (i_rst)
        (!chip_rst && i_host_bios_req && o_strap.boot_memory_enable) |=> o_host_bios_grant;
    endproperty
    a_grant: assert property (p_grant) else $error("bios grant missing"); // see RULE8
endmodule
`default_nettype wire

// ===== rtl/rsl_sync.sv
// two flip-flop level synchroniser for the chip reset pin
// assumes the pin is asynchronous to the reference clock
`timescale 1ns/100ps
`default_nettype none
module rsl_sync #(
    parameter int STAGES = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_d,
    output logic o_q
);
    // ------------------------------------------------------------
    // shift chain
    // ------------------------------------------------------------
    logic [STAGES-1:0] chain;   // first stage feeds only the next
    // sample without reset so pin level passes even while held low
    always_ff @(posedge i_ref_clk) begin
        chain <= {chain[STAGES-2:0], i_d};
    end
    assign o_q = chain[STAGES-1];
endmodule
`default_nettype wire

// ===== verif/rsl_board_model.sv
// board strap resistors and reset circuit as seen by the strap latch
// assumes the bench chooses the strap set and when the reset pin is held
`timescale 1ns/100ps
`default_nettype none
module rsl_board_model
    import rsl_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_hold_reset,       // keep reset pin low
    input wire rsl_strap_t i_strap_cfg,  // resistor levels to present
    output logic o_chip_reset_in_n,
    output rsl_strap_t o_strap_pins
);
    logic [3:0] rel_cnt = 4'h0;  // cycles since release
    logic [4:0] busy = 5'h00;    // normal-role traffic pattern
    initial o_chip_reset_in_n = 1'b0;
    // pin moves a little after the edge, like any bench input
    always @(posedge i_ref_clk) begin
        o_chip_reset_in_n <= #5 !i_hold_reset;
        rel_cnt <= #5 i_hold_reset ? 4'h0 : rel_cnt + {3'h0, rel_cnt != 4'hf};
        busy <= #5 busy + 5'h0b;
    end
    // straps stable around release, then the pins carry changing traffic
    assign o_strap_pins = rsl_strap_t'((i_hold_reset || rel_cnt < 4'h6) ?
        i_strap_cfg : ~i_strap_cfg ^ busy);
endmodule
`default_nettype wire

// ===== verif/rsl_reset_strap_latch_tb.sv
// self-checking bench for the reset strap latch
// assumes the board model drives reset pin and straps; the rest is driven here
`timescale 1ns/100ps
`default_nettype none
module rsl_reset_strap_latch_tb
    import rsl_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, hold = 1'b1, pin_n, wr = 1'b0, req = 1'b1;
    logic por = 1'b1, hrq = 1'b0, sci = 1'b0, s16n = 1'b0;
    logic inr, grant, ctm, s16, hrn, scin, rel;
    rsl_strap_t cfg = '0, pins, strap;
    logic [23:0] addr = 24'h0a5a5a, xaddr;
    logic [3:0] remap = 4'h9, rexp = 4'h0;
    logic [15:0] sn = 16'h3c3c, pll = 16'hc3a5, pull, scan;
    logic [7:0] csm, fen, fwh;
    int n_fail = 0, n_compared = 0;
    rsl_strap_t tbl [4] = '{rsl_strap_t'(5'h1f), rsl_strap_t'(5'h00),
        rsl_strap_t'(5'h0a), rsl_strap_t'(5'h15)};  // each field both ways
    always #25 clk = ~clk;
    rsl_board_model u_board (.i_ref_clk(clk), .i_hold_reset(hold), .i_strap_cfg(cfg),
        .o_chip_reset_in_n(pin_n), .o_strap_pins(pins));
    rsl_reset_strap_latch u_dut (.i_ref_clk(clk), .i_rst(rst), .i_chip_reset_in_n(pin_n),
        .i_strap_pins(pins), .i_lpc_addr(addr), .i_remap_address_reg(remap),
        .i_remap_wr(wr), .i_host_bios_req(req), .i_scan_normal(sn),
        .i_scan_16_normal(s16n), .i_pll_data(pll), .i_por(por),
        .i_host_reset_req(hrq), .i_sci_pending(sci), .o_in_reset(inr),
        .o_strap(strap), .o_expander_pullup_en(pull), .o_xbus_addr(xaddr),
        .o_lpc_chip_select_map_reg(csm), .o_lpc_flash_enable_reg(fen),
        .o_firmware_hub_id_reg(fwh), .o_host_bios_grant(grant),
        .o_clock_test_mode(ctm), .o_scan_output_lines(scan), .o_scan_output_16(s16),
        .o_host_reset_request_n(hrn), .o_sci_event_out_n(scin), .o_pins_released(rel));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    task automatic check_all();
        chk(24'(strap), 24'(cfg), "strap capture");
        chk(24'(pull), {16{cfg.expander_pullup}}, "pullups");
        chk(xaddr, cfg.remap_disable ? addr : {addr[23:21], rexp, addr[16:0]},
            "xaddr");
        chk(24'(csm), cfg.remap_disable ? 24'h0 : 24'h20, "map reg");
        chk(24'(fen), 24'({4{cfg.boot_memory_enable}}), "flash en");
        chk(24'(fwh), 24'({cfg.boot_memory_enable, 4'h0}), "hub id");
        chk(24'(grant), 24'(cfg.boot_memory_enable), "bios grant");
        chk(24'(ctm), 24'(cfg.clock_test), "clock test");
        chk(24'(scan), 24'(cfg.pll_test ? pll : sn), "scan lines");
        chk(24'(s16), 24'(cfg.pll_test ? por : s16n), "scan 16");
        chk(24'(inr), 24'h0, "out of reset");
    endtask
    task automatic finish_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        step(8);
        rst = 1'b0;
        wr = 1'b1;  // write while pin low must be lost
        hrq = 1'b1;
        sci = 1'b1;
        step(1);
        wr = 1'b0;
        step(4);
        chk(24'(inr), 24'h1, "in reset");
        chk(24'({hrn, scin, rel, grant}), 24'hc, "reset outputs");
        chk(24'({csm, fen, fwh}), 24'h0, "mirrors cleared");
        $display("reset test done");
        hrq = 1'b0;
        sci = 1'b0;
        foreach (tbl[i]) begin
            cfg = tbl[i];
            hold = 1'b1;
            rexp = RSL_REMAP_RST;  // remap copy clears with the chip
            por = ~por;  // both power-on levels reach scan 16
            step(5);
            remap = 4'hf;  // refused while held in reset
            wr = 1'b1;
            step(1);
            wr = 1'b0;
            chk(24'(inr), 24'h1, "held");
            hold = 1'b0;
            step(8);
            check_all();
            rexp = 4'(i) + 4'h3;
            remap = rexp;
            wr = 1'b1;
            step(1);
            wr = 1'b0;
            step(3);
            check_all();
            step(12);
            chk(24'(strap), 24'(cfg), "strap held");
            chk(24'(rel), 24'h1, "pins released");
            $display("strap set %0d done", i);
        end
        hrq = 1'b1;
        sci = 1'b1;
        step(3);
        chk(24'(hrn), 24'h0, "reset request");
        chk(24'(scin), 24'h0, "sci out");
        hrq = 1'b0;
        sci = 1'b0;
        req = 1'b0;
        step(3);
        chk(24'({hrn, scin}), 24'h3, "requests idle");
        chk(24'(grant), 24'h0, "grant without request");
        $display("host outputs done");
        finish_test();
    end
    // watchdog: tests need about 140 cycles
    initial begin
        #50000;
        n_fail++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        finish_test();
    end
endmodule
`default_nettype wire
